// File: dv/ribc_ctrl_assertions.sv
// Checker of the control block's ports.
// Assumes it is bound into every instance of the control block.
`timescale 1ns/100ps
`default_nettype none
module ribc_ctrl_assertions #(
  parameter int NUM_IRQ = 4
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic sys_reset_n_in,
  input wire logic float_n_in,
  input wire logic global_irq_mask_in,
  input wire logic mode_wr_in,
  input wire logic irq_ack_n_out,
  input wire logic irq_ack_oe_out,
  input wire logic core_halt_out,
  input wire logic core_reinit_out,
  input wire logic fetch_load_out,
  input wire logic [15:0] fetch_addr_out,
  input wire logic [NUM_IRQ-1:0] irq_mask_reg_out,
  input wire logic [NUM_IRQ-1:0] irq_flag_reg_out,
  input wire logic rom_mapped_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire logic line_load = fetch_load_out && fetch_addr_out[15:4] == 12'hffc;
  wire logic [1:0] num = fetch_addr_out[3:2];
  chk_ack_length: assert property (
    $fell(irq_ack_n_out) |-> (!irq_ack_n_out)[*3] ##1 irq_ack_n_out)
    else $error("Acknowledge low length wrong.");
  chk_ack_fetch: assert property (
    $fell(irq_ack_n_out) |-> fetch_load_out && fetch_addr_out != 16'hff80)
    else $error("Acknowledge without vector fetch.");
  chk_float_oe: assert property (
    (!float_n_in)[*3] |=> !irq_ack_oe_out)
    else $error("Acknowledge not floated.");
  chk_line_gated: assert property (
    line_load |-> !$past(global_irq_mask_in) && irq_mask_reg_out[num]
      && irq_flag_reg_out[num])
    else $error("Masked or idle line taken.");
  chk_lowest_first: assert property (
    line_load |-> (irq_flag_reg_out & irq_mask_reg_out
      & ((4'h1 << num) - 4'h1)) == 4'h0)
    else $error("Lower line passed over.");
  chk_reset_halt: assert property (
    (!sys_reset_n_in)[*4] |-> core_halt_out && core_reinit_out)
    else $error("Core runs during reset.");
  chk_reset_pc: assert property (
    $fell(core_halt_out) |-> ##[0:1]
      (fetch_load_out && fetch_addr_out == 16'hff80))
    else $error("Restart address wrong.");
  chk_rom_steady: assert property (
    $changed(rom_mapped_out) |-> $past(mode_wr_in) || $past(mode_wr_in, 2)
      || $past(core_halt_out) || $past(core_halt_out, 3))
    else $error("Memory map changed outside reset.");
  cover property (line_load);
  cover property (fetch_load_out && fetch_addr_out == 16'hff88);
  cover property ($fell(rom_mapped_out));
endmodule : ribc_ctrl_assertions
bind ribc_ctrl ribc_ctrl_assertions #(.NUM_IRQ(NUM_IRQ)) chk (.clk_in,
  .srst_in, .sys_reset_n_in, .float_n_in, .global_irq_mask_in, .mode_wr_in,
  .irq_ack_n_out, .irq_ack_oe_out, .core_halt_out, .core_reinit_out,
  .fetch_load_out, .fetch_addr_out, .irq_mask_reg_out, .irq_flag_reg_out,
  .rom_mapped_out);
`default_nettype wire

// File: dv/ribc_src_model.sv
// Model of the board's interrupt sources and reset circuit.
// Assumes one-cycle request pulses from the testbench at clock edges.
`timescale 1ns/100ps
`default_nettype none
module ribc_src_model #(
  parameter int RST_CYC = 8
) (
  // Clock.
  input wire logic clk_in,
  // Requests.
  input wire logic [3:0] irq_req_in,
  input wire logic nmi_req_in,
  input wire logic rst_req_in,
  // Pins.
  output logic [3:0] ext_irq_n_out,
  output logic nmi_n_out,
  output logic sys_reset_n_out
);
  int rst_cnt = 0;
  // Lines idle high under pull-ups; a request pulls one low for a cycle.
  always @(posedge clk_in) begin
    ext_irq_n_out <= ~irq_req_in;
    nmi_n_out <= ~nmi_req_in;
  end
  // Reset is held low long enough for reinitialisation to finish.
  always @(posedge clk_in) begin
    if (rst_req_in) begin
      rst_cnt <= RST_CYC;
    end else if (rst_cnt > 0) begin
      rst_cnt <= rst_cnt - 1;
    end
    sys_reset_n_out <= !(rst_req_in || rst_cnt > 1);
  end
endmodule : ribc_src_model
`default_nettype wire

// File: dv/test_reset_irq_boot_control.sv
// Self-checking testbench of the reset, interrupt and boot-map block.
// Assumes the package, source model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_reset_irq_boot_control;
  import ribc_pkg::*;
  logic clk_in = 1'h0, srst_in = 1'h1, boot = 1'h0, float_n = 1'h1;
  logic gmask = 1'h0, mwr = 1'h0, fclr = 1'h0, mode_wr = 1'h0;
  logic mode_d = 1'h0, ready = 1'h0, nmi_req = 1'h0, rst_req = 1'h0;
  logic [3:0] mdat = 4'h0, fdat = 4'h0, irq_req = 4'h0, irq_n, mreg, freg;
  logic rst_n, nmi_n, ack_n, oe, halt, reinit, load, rom;
  logic [15:0] addr;
  ribc_status_t stat;
  int error_cnt = 0, checked = 0;
  initial forever #50 clk_in = ~clk_in;
  ribc_src_model src (.clk_in, .irq_req_in(irq_req), .nmi_req_in(nmi_req),
    .rst_req_in(rst_req), .ext_irq_n_out(irq_n), .nmi_n_out(nmi_n),
    .sys_reset_n_out(rst_n));
  ribc_ctrl uut (.clk_in, .srst_in, .sys_reset_n_in(rst_n),
    .ext_irq_n_in(irq_n), .nmi_n_in(nmi_n), .boot_map_select_in(boot),
    .float_n_in(float_n), .irq_ack_n_out(ack_n), .irq_ack_oe_out(oe),
    .global_irq_mask_in(gmask), .irq_mask_wr_in(mwr),
    .irq_mask_wdata_in(mdat), .irq_flag_clr_in(fclr),
    .irq_flag_clr_data_in(fdat), .mode_wr_in(mode_wr),
    .mode_wdata_in(mode_d), .core_ready_in(ready), .core_halt_out(halt),
    .core_reinit_out(reinit), .fetch_load_out(load), .fetch_addr_out(addr),
    .irq_mask_reg_out(mreg), .irq_flag_reg_out(freg),
    .rom_mapped_out(rom), .status_out(stat));
  task automatic cmp(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  // Returns the next loaded fetch address, or zero when none comes.
  task automatic wait_load(output logic [15:0] a);
    a = 16'h0;
    for (int i = 0; i < 40 && a == 16'h0; i++) begin
      @(negedge clk_in);
      if (load === 1'h1) a = addr;
    end
    cyc(1);
  endtask : wait_load
  task automatic t_boot(input logic sel, input logic [15:0] exp_rom);
    logic [15:0] a;
    boot <= sel;
    rst_req <= 1'h1;
    cyc(1);
    rst_req <= 1'h0;
    cyc(5);
    cmp("halt_reinit", 16'h3, {14'h0, halt, reinit});
    wait_load(a);
    cmp("reset_pc", 16'hff80, a);
    cmp("rom_mapped", exp_rom, {15'h0, rom});
    boot <= ~sel;
    cyc(6);
    cmp("rom_hold", exp_rom, {15'h0, rom});
  endtask : t_boot
  task automatic t_mode(input logic v, input logic [15:0] exp_rom);
    mode_d <= v;
    mode_wr <= 1'h1;
    cyc(1);
    mode_wr <= 1'h0;
    cyc(3);
    cmp("mode_override", exp_rom, {15'h0, rom});
  endtask : t_mode
  task automatic t_irq;
    logic [15:0] a;
    mwr <= 1'h1;
    mdat <= 4'hf;
    irq_req <= 4'h6;
    cyc(1);
    mwr <= 1'h0;
    irq_req <= 4'h0;
    cyc(6);
    cmp("flags", 16'h6, {12'h0, freg});
    ready <= 1'h1;
    wait_load(a);
    cmp("first_line", 16'hffc4, a);
    cmp("ack_n", 16'h0, {15'h0, ack_n});
    wait_load(a);
    cmp("second_line", 16'hffc8, a);
    cyc(3);
    cmp("flags_taken", 16'h0, {12'h0, freg});
  endtask : t_irq
  task automatic t_mask;
    logic [15:0] a;
    mwr <= 1'h1;
    mdat <= 4'hb;
    irq_req <= 4'h4;
    cyc(1);
    mwr <= 1'h0;
    irq_req <= 4'h0;
    wait_load(a);
    cmp("masked_line", 16'h0, a);
    cmp("masked_flag", 16'h4, {12'h0, freg});
    cmp("mask_reg", 16'hb, {12'h0, mreg});
    fclr <= 1'h1;
    fdat <= 4'h4;
    cyc(1);
    fclr <= 1'h0;
    cyc(3);
    cmp("flag_clear", 16'h0, {12'h0, freg});
  endtask : t_mask
  task automatic t_nmi;
    logic [15:0] a;
    gmask <= 1'h1;
    mwr <= 1'h1;
    mdat <= 4'h1;
    irq_req <= 4'h1;
    nmi_req <= 1'h1;
    cyc(1);
    mwr <= 1'h0;
    irq_req <= 4'h0;
    nmi_req <= 1'h0;
    wait_load(a);
    cmp("nmi_vector", 16'hff88, a);
    wait_load(a);
    cmp("global_mask", 16'h0, a);
    cmp("status", 16'h046, {6'h0, stat});
  endtask : t_nmi
  task automatic t_float;
    float_n <= 1'h0;
    cyc(5);
    cmp("ack_float", 16'h0, {15'h0, oe});
    float_n <= 1'h1;
    cyc(5);
    cmp("ack_drive", 16'h1, {15'h0, oe});
  endtask : t_float
  task automatic complete_run;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    cyc(4);
    srst_in <= 1'h0;
    cyc(10);
    t_boot(1'h0, 16'h1);
    t_boot(1'h1, 16'h0);
    t_mode(1'h0, 16'h1);
    t_mode(1'h1, 16'h0);
    t_irq;
    t_mask;
    t_nmi;
    t_float;
    complete_run;
  end
  initial begin
    cyc(3000);
    error_cnt++;
    complete_run;
  end
endmodule : test_reset_irq_boot_control
`default_nettype wire

// File: logic/ribc_ctrl.sv
// Reset, external interrupt and boot-map control logic of the processor.
// Assumes all pins arrive asynchronously and one 10 MHz machine clock.
`timescale 1ns/100ps
`default_nettype none
`include "ribc_map.svh"

// What this block does
// R1: On accepting an interrupt, drive acknowledge low while the vector is on the low address lines.
// R2: Float acknowledge whenever the output-float input is low.
// R3: Serve the four maskable inputs by priority, each blockable by its mask bit.
// R4: Show the pending state of each maskable input in the flag register.
// R5: Take the non-maskable interrupt whatever the global and per-line masks say.
// R6: Send the non-maskable interrupt to its own vector.
// R7: While reset is low, stop execution and reinitialise all state.
// R8: On reset release, start fetching at 0FF80h.
// R9: Boot-map select low at reset maps internal ROM into the top 16K words.
// R10: Boot-map select high at reset removes the ROM from program space.
// R11: Boot-map select is sampled only during reset.
// R12: A writable mode bit overrides the latched ROM mapping.
// R13: Lowest-numbered pending input wins and its flag clears on acknowledge.
// R14: The reset source holds reset low for several machine cycles.
module ribc_ctrl #(
  parameter int NUM_IRQ = `RIBC_NUM_IRQ
) (
  // Clock and block reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Pins.
  input wire logic sys_reset_n_in,
  input wire logic [NUM_IRQ-1:0] ext_irq_n_in,
  input wire logic nmi_n_in,
  input wire logic boot_map_select_in,
  input wire logic float_n_in,
  output logic irq_ack_n_out,
  output logic irq_ack_oe_out,
  // Core side.
  input wire logic global_irq_mask_in,
  input wire logic irq_mask_wr_in,
  input wire logic [NUM_IRQ-1:0] irq_mask_wdata_in,
  input wire logic irq_flag_clr_in,
  input wire logic [NUM_IRQ-1:0] irq_flag_clr_data_in,
  input wire logic mode_wr_in,
  input wire logic mode_wdata_in,
  input wire logic core_ready_in,
  output logic core_halt_out,
  output logic core_reinit_out,
  output logic fetch_load_out,
  output logic [15:0] fetch_addr_out,
  output logic [NUM_IRQ-1:0] irq_mask_reg_out,
  output logic [NUM_IRQ-1:0] irq_flag_reg_out,
  output logic rom_mapped_out,
  output ribc_pkg::ribc_status_t status_out
);
  import ribc_pkg::*;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [NUM_IRQ+3:0] pin_s1_reg;
  logic [NUM_IRQ+3:0] pin_s2_reg;

  // Block reset shows the reset pin as held and boot select as low, so
  // the core stays halted until the real pin is seen high and the map
  // keeps its default.
  localparam logic [NUM_IRQ+3:0] PIN_START = {1'b1, 1'b0, 1'b1, 1'b0,
                                              {NUM_IRQ{1'b1}}};

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_s1_reg <= PIN_START;
      pin_s2_reg <= PIN_START;
    end else begin
      pin_s1_reg <= {float_n_in, boot_map_select_in, nmi_n_in,
                     sys_reset_n_in, ext_irq_n_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Only the second stage is read; the first may still be settling.
  logic [NUM_IRQ-1:0] irq_lvl;
  logic rst_active;
  logic nmi_lvl;
  logic boot_sel;
  logic float_n;
  assign irq_lvl = ~pin_s2_reg[NUM_IRQ-1:0];
  assign rst_active = ~pin_s2_reg[NUM_IRQ];
  assign nmi_lvl = ~pin_s2_reg[NUM_IRQ+1];
  assign boot_sel = pin_s2_reg[NUM_IRQ+2];
  assign float_n = pin_s2_reg[NUM_IRQ+3];

  // ****************************************************************
  // Edge detection of interrupt and reset inputs.
  // ****************************************************************
  // Requests latch on the falling pin edge, so a line held low is served
  // once; the reset edge marks the cycle in which the pin is seen high.
  logic [NUM_IRQ-1:0] irq_prev_reg;
  logic nmi_prev_reg;
  logic rst_prev_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_prev_reg <= '0;
      nmi_prev_reg <= 1'b0;
      rst_prev_reg <= 1'b1;
    end else begin
      irq_prev_reg <= irq_lvl;
      nmi_prev_reg <= nmi_lvl;
      rst_prev_reg <= rst_active;
    end
  end

  logic [NUM_IRQ-1:0] irq_rise;
  logic nmi_rise;
  logic rst_release;
  assign irq_rise = irq_lvl & ~irq_prev_reg;
  assign nmi_rise = nmi_lvl & ~nmi_prev_reg;
  assign rst_release = rst_prev_reg & ~rst_active;

  // ****************************************************************
  // Sequencer state and priority selection.
  // ****************************************************************
  ribc_state_t state_reg;
  logic [3:0] ack_cnt_reg;
  logic nmi_pend_reg;
  logic [NUM_IRQ-1:0] mask_reg;
  logic [NUM_IRQ-1:0] flag_reg;
  logic [NUM_IRQ-1:0] eligible;
  logic [NUM_IRQ-1:0] take_onehot;
  logic [15:0] take_vector;
  logic take_any;

  // Lowest-numbered eligible line wins.
  assign eligible = flag_reg & mask_reg & {NUM_IRQ{~global_irq_mask_in}}; // R3

  // Scanning down from the top lets the lowest eligible line win.
  always_comb begin
    take_onehot = '0;
    take_vector = `RIBC_INT_VECTOR_BASE;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (eligible[i]) begin // R13
        take_onehot = '0;
        take_onehot[i] = 1'b1;
        take_vector = `RIBC_INT_VECTOR_BASE + 16'(i * 4);
      end
    end
  end

  logic start_nmi;
  logic start_irq;
  // One request is taken at a time; anything arriving during the
  // acknowledge waits in its flag or latch until the sequencer is idle.
  // The non-maskable request is served before any maskable line.
  assign take_any = |eligible;
  assign start_nmi = (state_reg == RIBC_IDLE) && core_ready_in &&
                     nmi_pend_reg; // R5
  assign start_irq = (state_reg == RIBC_IDLE) && core_ready_in &&
                     !nmi_pend_reg && take_any;

  always_ff @(posedge clk_in) begin
    if (srst_in || rst_active) begin
      state_reg <= RIBC_RESET; // R7
      ack_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        RIBC_RESET: begin
          if (rst_release) begin
            state_reg <= RIBC_IDLE;
          end
        end
        RIBC_IDLE: begin
          if (start_nmi || start_irq) begin
            state_reg <= RIBC_ACK;
            ack_cnt_reg <= `RIBC_ACK_CYCLES;
          end
        end
        RIBC_ACK: begin
          if (ack_cnt_reg == 4'h1) begin
            state_reg <= RIBC_IDLE;
          end
          ack_cnt_reg <= ack_cnt_reg - 4'h1;
        end
        // The spare code falls back to reset.
        default: begin
          state_reg <= RIBC_RESET;
        end
      endcase
    end
  end

  // ****************************************************************
  // Non-maskable request latch.
  // ****************************************************************
  // A new edge wins over the accept in the same cycle, so a request that
  // arrives while the previous one is taken is kept.
  always_ff @(posedge clk_in) begin
    if (srst_in || rst_active) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_rise) begin
      nmi_pend_reg <= 1'b1; // R5
    end else if (start_nmi) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Mask and flag registers.
  // ****************************************************************
  // A mask bit of one lets its line through; reset blocks every line.
  always_ff @(posedge clk_in) begin
    if (srst_in || rst_active) begin
      mask_reg <= '0; // R7
    end else if (irq_mask_wr_in) begin
      mask_reg <= irq_mask_wdata_in; // R3
    end
  end

  // A new edge wins over a software clear or acknowledge in the same cycle.
  always_ff @(posedge clk_in) begin
    if (srst_in || rst_active) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (flag_reg
                   & ~(irq_flag_clr_in ? irq_flag_clr_data_in : '0)
                   & ~(start_irq ? take_onehot : '0)) // R13
                  | irq_rise; // R4
    end
  end

  // ****************************************************************
  // Boot map mode.
  // ****************************************************************
  // While reset is held the map follows the pin every cycle, so the value
  // seen just before release is kept; later pin changes are ignored and
  // only a mode write moves the map.
  logic rom_mapped_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rom_mapped_reg <= 1'b1;
    end else if (rst_active) begin
      rom_mapped_reg <= ~boot_sel; // R9 R10 R11
    end else if (mode_wr_in) begin
      rom_mapped_reg <= ~mode_wdata_in; // R12
    end
  end

  // ****************************************************************
  // Output registers.
  // ****************************************************************
  // Acknowledge goes low with the vector fetch and is released after the
  // acknowledge count, or on the cycle after reset puts the sequencer in RIBC_RESET.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_ack_n_out <= 1'b1;
      irq_ack_oe_out <= 1'b1;
      fetch_load_out <= 1'b0;
      fetch_addr_out <= `RIBC_RESET_PC;
      core_halt_out <= 1'b1;
      core_reinit_out <= 1'b1;
    end else begin
      irq_ack_oe_out <= float_n; // R2
      core_halt_out <= rst_active; // R7
      core_reinit_out <= rst_active; // R7
      fetch_load_out <= 1'b0;
      if (state_reg == RIBC_IDLE && (start_nmi || start_irq)) begin
        irq_ack_n_out <= 1'b0; // R1
      end else if (state_reg == RIBC_ACK && ack_cnt_reg == 4'h1) begin
        irq_ack_n_out <= 1'b1;
      end else if (state_reg == RIBC_RESET) begin
        irq_ack_n_out <= 1'b1;
      end
      if (state_reg == RIBC_RESET && rst_release) begin
        fetch_load_out <= 1'b1;
        fetch_addr_out <= `RIBC_RESET_PC; // R8
      end else if (start_nmi) begin
        fetch_load_out <= 1'b1;
        fetch_addr_out <= `RIBC_NMI_VECTOR; // R6
      end else if (start_irq) begin
        fetch_load_out <= 1'b1;
        fetch_addr_out <= take_vector; // R1
      end
    end
  end

  // Copies for software polling; flags show the latched edges.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_mask_reg_out <= '0;
      irq_flag_reg_out <= '0;
      rom_mapped_out <= 1'b1;
      status_out <= '0;
    end else begin
      irq_mask_reg_out <= mask_reg;
      irq_flag_reg_out <= flag_reg; // R4
      rom_mapped_out <= rom_mapped_reg;
      status_out <= '{flags: flag_reg, mask: mask_reg,
                      global_mask: global_irq_mask_in,
                      rom_mapped: rom_mapped_reg};
    end
  end

endmodule : ribc_ctrl
`default_nettype wire

// File: logic/ribc_map.svh
// Constants for the reset, interrupt and boot-mode control block.
// Assumes inclusion by name from the design package and module.
`ifndef RIBC_MAP_SVH
`define RIBC_MAP_SVH

`define RIBC_RESET_PC 16'hff80
`define RIBC_NMI_VECTOR 16'hff88
`define RIBC_INT_VECTOR_BASE 16'hffc0
`define RIBC_ROM_BASE 16'hc000
`define RIBC_NUM_IRQ 4
`define RIBC_ACK_CYCLES 4'h3
`define RIBC_RESET_MIN_CYCLES 4'h4

`endif

// File: logic/ribc_pkg.sv
// Types for the reset, interrupt and boot-mode control block.
// Assumes the constants header is on the include path.
`include "ribc_map.svh"

package ribc_pkg;

  // Mode states of the acknowledge sequencer.
  typedef enum logic [1:0] {
    RIBC_IDLE = 2'b00,
    RIBC_ACK = 2'b01,
    RIBC_RESET = 2'b10
  } ribc_state_t;

  // Bus-like status view.
  typedef struct packed {
    logic [3:0] flags;
    logic [3:0] mask;
    logic global_mask;
    logic rom_mapped;
  } ribc_status_t;

endpackage : ribc_pkg
